//--- core/fswdt_defines.vh
// Purpose: shared constants of the fail-safe watchdog
// Assumes: 10 MHz system clock
// Notes: definitions only
`ifndef FSWDT_DEFINES_VH
`define FSWDT_DEFINES_VH

// clock and timing
`define FSWDT_CLK_PERIOD_NS 100
`define FSWDT_WARN_TIME_NS 1600
`define FSWDT_WARN_CYCLES (`FSWDT_WARN_TIME_NS / `FSWDT_CLK_PERIOD_NS)

// prescaler factors and widths
`define FSWDT_DIV_SLOW 16384
`define FSWDT_DIV_FAST 256
`define FSWDT_PRE_W 14
`define FSWDT_CNT_W 16
`define FSWDT_REL_W 8

// reset defaults: 256 ticks of 256 cycles, about 6.5 ms at 10 MHz
`define FSWDT_REL_RESET 8'hff
`define FSWDT_SEL_RESET 1'b0
`define FSWDT_CNT_ALL_ONES 16'hffff

// states
`define FSWDT_ST_OFF 2'h0
`define FSWDT_ST_RUN 2'h1
`define FSWDT_ST_WARN 2'h2
`define FSWDT_ST_RESET 2'h3

`endif

//--- core/fswdt_prescaler.v
// Purpose: selectable clock divider giving a one-cycle tick
// Assumes: single clock, tick is a clock enable
// Notes: clear restarts the division from zero
`timescale 1ns/10ps
`include "fswdt_defines.vh"

module fswdt_prescaler #(
   parameter DIV_SLOW = `FSWDT_DIV_SLOW,
   parameter DIV_FAST = `FSWDT_DIV_FAST
) (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // control
   input wire run,
   input wire clear,
   input wire selSlow,
   // tick
   output reg tick_ff
);

   reg [`FSWDT_PRE_W-1:0] preCnt_ff;
   wire [`FSWDT_PRE_W-1:0] preLast;
   wire atLast;

   // last count of the chosen division
   assign preLast = selSlow ? DIV_SLOW[`FSWDT_PRE_W-1:0] - 14'h0001 : DIV_FAST[`FSWDT_PRE_W-1:0] - 14'h0001;
   assign atLast = (preCnt_ff >= preLast);

   // divider counter and tick
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         preCnt_ff <= 14'h0000;
         tick_ff <= 1'b0;
      end else if (clear || !run) begin
         preCnt_ff <= 14'h0000;
         tick_ff <= 1'b0;
      end else if (atLast) begin
         preCnt_ff <= 14'h0000;
         tick_ff <= 1'b1;
      end else begin
         preCnt_ff <= preCnt_ff + 14'h0001;
         tick_ff <= 1'b0;
      end
   end

endmodule // fswdt_prescaler

//--- core/fswdt_top.v
// Purpose: fail-safe watchdog timer with prewarning and reset request
// Assumes: commands are one-cycle strobes from core logic on clk
// Notes: reload value loads the upper byte of the counter
//        service during the prewarning cancels the reset request
`timescale 1ns/10ps
`include "fswdt_defines.vh"

module fswdt_top #(
   parameter CNT_W = `FSWDT_CNT_W,
   parameter REL_W = `FSWDT_REL_W,
   parameter WARN_CYCLES = `FSWDT_WARN_CYCLES
) (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // processor commands
   input wire guardServiceCmd,
   input wire guardDisableCmd,
   input wire guardEnableCmd,
   // configuration write
   input wire cfgWrite,
   input wire [REL_W-1:0] guardReloadValue,
   input wire prescSelSlow,
   // status and events
   output reg running_ff,
   output reg [CNT_W-1:0] guardCount_ff,
   output reg prewarnIrq_ff,
   output reg resetReq_ff
);

   // sequencer and counter state
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [REL_W-1:0] reload_ff;
   reg selSlow_ff;
   reg [7:0] warnCnt_ff;
   reg [7:0] nxt_warnCnt;
   reg [CNT_W-1:0] nxt_count;
   reg presClear;
   // prescaler tick and state decodes
   wire tick;
   wire overflow;
   wire inRun;
   wire toWarn;
   wire toReset;

   // state codes of the guard sequencer
   localparam [1:0] ST_OFF = `FSWDT_ST_OFF;
   localparam [1:0] ST_RUN = `FSWDT_ST_RUN;
   localparam [1:0] ST_WARN = `FSWDT_ST_WARN;
   localparam [1:0] ST_RESET = `FSWDT_ST_RESET;
   // start value of the prewarning countdown, which counts down to zero
   localparam [7:0] WARN_LAST = WARN_CYCLES[7:0] - 8'h01;

   // full counter start value from reload byte
   function [CNT_W-1:0] startValue;
      input [REL_W-1:0] rel;
      begin
         startValue = {rel, {(CNT_W-REL_W){1'b0}}};
      end
   endfunction

   // divider gives the counter its tick, held at zero while not running
   fswdt_prescaler #(
      .DIV_SLOW(`FSWDT_DIV_SLOW),
      .DIV_FAST(`FSWDT_DIV_FAST)
   ) u_presc (
      .clk(clk),
      .rst_b(rst_b),
      .run(inRun),
      .clear(presClear),
      .selSlow(selSlow_ff),
      .tick_ff(tick)
   );

   // wrap past all ones on a tick
   assign overflow = tick && (guardCount_ff == `FSWDT_CNT_ALL_ONES);

   // state decodes shared by the prescaler and the event outputs
   assign inRun = (state_ff == ST_RUN);
   assign toWarn = inRun && (nxt_state == ST_WARN);
   assign toReset = (nxt_state == ST_RESET);

   // configuration, defaults set the default interval
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reload_ff <= `FSWDT_REL_RESET;
         selSlow_ff <= `FSWDT_SEL_RESET;
      end else if (cfgWrite) begin
         reload_ff <= guardReloadValue;
         selSlow_ff <= prescSelSlow;
      end
   end

   // next state, counter and prescaler clear
   always @* begin
      nxt_state = state_ff;
      nxt_count = guardCount_ff;
      nxt_warnCnt = warnCnt_ff;
      presClear = 1'b0;
      case (state_ff)
         ST_OFF: begin
            // enable restarts from the held count
            if (guardEnableCmd && !guardDisableCmd) begin
               nxt_state = ST_RUN;
               presClear = 1'b1;
            end
            // service while stopped only loads the counter
            if (guardServiceCmd) begin
               nxt_count = startValue(reload_ff);
            end
         end
         ST_RUN: begin
            // service wins over a tick in the same cycle
            if (guardServiceCmd) begin
               nxt_count = startValue(reload_ff);
               presClear = 1'b1;
            end else if (tick) begin
               nxt_count = guardCount_ff + 16'h0001;
            end
            // disable wins, service suppresses the prewarning
            if (guardDisableCmd) begin
               nxt_state = ST_OFF;
            end else if (overflow && !guardServiceCmd) begin
               nxt_state = ST_WARN;
               nxt_warnCnt = WARN_LAST;
            end
         end
         ST_WARN: begin
            // late service cancels the pending reset request
            if (guardServiceCmd) begin
               nxt_state = ST_RUN;
               nxt_count = startValue(reload_ff);
               presClear = 1'b1;
            end else if (guardDisableCmd) begin
               nxt_state = ST_OFF;
            end else if (warnCnt_ff == 8'h00) begin
               nxt_state = ST_RESET;
            end else begin
               nxt_warnCnt = warnCnt_ff - 8'h01;
            end
         end
         ST_RESET: begin
            // only a new reset leaves this state
            nxt_state = ST_RESET;
         end
         default: begin
            nxt_state = ST_OFF;
         end
      endcase
   end

   // sequencer state, running after every reset
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // guard counter, starts at the default reload
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         guardCount_ff <= {`FSWDT_REL_RESET, 8'h00};
      end else begin
         guardCount_ff <= nxt_count;
      end
   end

   // prewarning countdown
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         warnCnt_ff <= 8'h00;
      end else begin
         warnCnt_ff <= nxt_warnCnt;
      end
   end

   // running level follows the next state
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         running_ff <= 1'b1;
      end else begin
         running_ff <= (nxt_state == ST_RUN);
      end
   end

   // one-cycle prewarning on the run to warn step
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prewarnIrq_ff <= 1'b0;
      end else begin
         prewarnIrq_ff <= toWarn;
      end
   end

   // reset request, held until the next reset
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         resetReq_ff <= 1'b0;
      end else begin
         resetReq_ff <= toReset;
      end
   end

endmodule // fswdt_top

//--- bench/fswdt_chk.sv
// Purpose: port checks of the watchdog
// Assumes: prewarning to reset delay of 16
// Notes: bound to fswdt_top
`timescale 1ns/10ps
module fswdt_chk(
   // watched ports
   input wire clk,
   input wire rst_b,
   input wire guardServiceCmd,
   input wire guardDisableCmd,
   input wire cfgWrite,
   input wire running_ff,
   input wire prewarnIrq_ff,
   input wire resetReq_ff,
   input wire [15:0] guardCount_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_rst; $rose(rst_b) |-> running_ff && guardCount_ff == 16'hff00; endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   property p_dis; guardDisableCmd |=> !running_ff; endproperty
   a_dis: assert property (p_dis) else $error("disable ignored");
   property p_srv; guardServiceCmd && running_ff |=> running_ff && guardCount_ff[7:0] == 8'h00; endproperty
   a_srv: assert property (p_srv) else $error("service did not reload");
   property p_step; running_ff && !guardServiceCmd && !cfgWrite |=> guardCount_ff - $past(guardCount_ff) <= 16'h0001; endproperty
   a_step: assert property (p_step) else $error("count jumped");
   property p_ovf; $rose(prewarnIrq_ff) |-> $past(guardCount_ff) == 16'hffff && !running_ff; endproperty
   a_ovf: assert property (p_ovf) else $error("prewarning without overflow");
   property p_pls; prewarnIrq_ff |=> !prewarnIrq_ff; endproperty
   a_pls: assert property (p_pls) else $error("prewarning too long");
   property p_ord; $rose(resetReq_ff) |-> $past(prewarnIrq_ff, 16); endproperty
   a_ord: assert property (p_ord) else $error("reset request out of order");
   property p_hold; resetReq_ff |=> resetReq_ff && !running_ff; endproperty
   a_hold: assert property (p_hold) else $error("reset request dropped");
endmodule // fswdt_chk
bind fswdt_top fswdt_chk u_fswdt_chk(.*);

//--- bench/fswdt_core_model.sv
// Purpose: processor core issuing watchdog commands
// Assumes: one-cycle strobes on clk
// Notes: periodic service when a gap is set
`timescale 1ns/10ps
module fswdt_core_model(
   // clock
   input wire clk,
   // bench requests: service, disable, enable
   input wire [2:0] cmdReq,
   input wire [15:0] servGap,
   // strobes to the watchdog
   output reg srvStb_ff = 1'b0,
   output reg disStb_ff = 1'b0,
   output reg enStb_ff = 1'b0
);
   reg [15:0] gap_ff = 16'h0000;
   // strobes follow requests one cycle later
   always @(posedge clk) begin
      gap_ff <= (gap_ff >= servGap) ? 16'h0000 : gap_ff + 16'h0001;
      srvStb_ff <= cmdReq[0] | (servGap != 16'h0000 && gap_ff == servGap);
      disStb_ff <= cmdReq[1];
      enStb_ff <= cmdReq[2];
   end
endmodule // fswdt_core_model

//--- bench/test_fswdt_top.sv
// Purpose: self-checking bench of the watchdog
// Assumes: default prewarning delay
// Notes: rows give command mask and running level
`timescale 1ns/10ps
module test_fswdt_top;
   reg clk = 1'b0, rst_b = 1'b0, cfgWrite = 1'b0, slow = 1'b0;
   reg [7:0] rel = 8'hff;
   reg [2:0] cmdReq = 3'h0;
   reg [15:0] servGap = 16'h0000;
   wire srv, dis, en, run, warn, rreq;
   wire [15:0] cnt;
   integer bad_count = 0, compares = 0, i, n;
   reg [3:0] rows [0:6] = '{4'h4, 4'h9, 4'h3, 4'h9, 4'hc, 4'h2, 4'h9};
   fswdt_core_model u_fswdt_core_model(.clk(clk), .cmdReq(cmdReq), .servGap(servGap),
      .srvStb_ff(srv), .disStb_ff(dis), .enStb_ff(en));
   fswdt_top u_fswdt_top(.clk(clk), .rst_b(rst_b), .guardServiceCmd(srv), .guardDisableCmd(dis),
      .guardEnableCmd(en), .cfgWrite(cfgWrite), .guardReloadValue(rel), .prescSelSlow(slow),
      .running_ff(run), .guardCount_ff(cnt), .prewarnIrq_ff(warn), .resetReq_ff(rreq));
   // clock
   initial begin
      forever #50 clk = ~clk;
   end
   task check(input [15:0] exp, input [15:0] got, input string what);
      compares = compares + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("wrong value %0s expected %h seen %h", what, exp, got);
      end
   endtask
   // one command, settled output after the design takes it
   task cmd(input [2:0] c);
      @(posedge clk) cmdReq <= c;
      @(posedge clk) cmdReq <= 3'h0;
      @(posedge clk);
      #1;
   endtask
   task print_verdict;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // hang guard
   initial begin
      #9500000;
      bad_count = bad_count + 1;
      print_verdict;
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      check(16'h0001, run, "run after reset");
      check(16'hff00, cnt, "count after reset");
      n = 1;
      while (warn !== 1'b1 && n < 70000) begin
         @(posedge clk);
         #1;
         n = n + 1;
      end
      check(16'h0001, n >= 65536 && n <= 65540, "default interval");
      repeat (16) @(posedge clk);
      #1;
      check(16'h0001, rreq, "reset request");
      @(posedge clk) rst_b <= 1'b0;
      @(posedge clk) rst_b <= 1'b1;
      for (i = 0; i < 7; i = i + 1) begin
         cmd(rows[i][3:1]);
         check(rows[i][0], run, "running");
         if (rows[i][1]) check(16'hff00, cnt, "reloaded count");
      end
      servGap <= 16'd200;
      n = 0;
      for (i = 0; i < 1000; i = i + 1) begin
         @(posedge clk);
         n = n + (warn === 1'b1);
      end
      check(16'h0000, n, "prewarnings while serviced");
      check(16'hff00, cnt, "count while serviced");
      servGap <= 16'h0000;
      @(posedge clk) cfgWrite <= 1'b1;
      rel <= 8'h12;
      slow <= 1'b1;
      @(posedge clk) cfgWrite <= 1'b0;
      cmd(3'h1);
      repeat (2000) @(posedge clk);
      check(16'h1200, cnt, "slow prescaler");
      @(posedge clk) cfgWrite <= 1'b1;
      slow <= 1'b0;
      @(posedge clk) cfgWrite <= 1'b0;
      cmd(3'h1);
      repeat (300) @(posedge clk);
      check(16'h1201, cnt, "fast prescaler");
      print_verdict;
   end
endmodule // test_fswdt_top
